/* logic/wct_map.svh */
// Purpose: Register offsets, field positions, reset value and response codes of the wide counter.
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register.
// Notes: Printed offsets 0x1..0xa are indices; the byte address is four times the index.
`ifndef WCT_MAP_SVH
`define WCT_MAP_SVH

`define WCT_IDX_MODE 4'h1
`define WCT_IDX_CTRL 4'h2
`define WCT_IDX_SYNC 4'h3
`define WCT_IDX_RELOAD_LO 4'h4
`define WCT_IDX_RELOAD_HI 4'h5
`define WCT_IDX_CAPT_LO 4'h6
`define WCT_IDX_CAPT_HI 4'h7
`define WCT_IDX_IRQ_STAT 4'h8
`define WCT_IDX_IRQ_MASK 4'h9
`define WCT_IDX_PORT_OUT 4'ha

`define WCT_MODE_DEMOD 7
`define WCT_MODE_INIT_LVL 0
`define WCT_MODE_FORCE_HI 3
`define WCT_MODE_FORCE_LO 2
`define WCT_MODE_EDGE_HI 5
`define WCT_MODE_EDGE_LO 4
`define WCT_MODE_PINGPONG 1

`define WCT_CTRL_RUN 7
`define WCT_CTRL_ONESHOT 6
`define WCT_CTRL_TIMEOUT 5
`define WCT_CTRL_PRESC_HI 4
`define WCT_CTRL_PRESC_LO 3
`define WCT_CTRL_CAPT_IE 2
`define WCT_CTRL_EXPIRY_IE 1
`define WCT_CTRL_PIN35 0

`define WCT_SYNC_WIDE_EN 7
`define WCT_SYNC_NARROW_EN 6
`define WCT_SYNC_MODE 5

`define WCT_IRQ_EXPIRY 0
`define WCT_IRQ_CAPTURE 1

`define WCT_RESET_BYTE 8'h00
`define WCT_RESP_OKAY 2'b00
`define WCT_RESP_SLVERR 2'b10

`endif

/* logic/wct_pkg.sv */
// Purpose: Types shared by the wide counter files.
// Assumes: Nothing beyond the map header.
// Notes: Offsets and field positions live in wct_map.svh.
package wct_pkg;
    typedef enum logic [1:0] {
        WCT_IDLE = 2'b00,
        WCT_RUN = 2'b01,
        WCT_WAIT_EDGE = 2'b10,
        WCT_HALT = 2'b11
    } wct_state_t;
endpackage

/* logic/wct_prescaler.sv */
// Purpose: Makes the counting tick of the wide counter from the system clock.
// Assumes: Select 0..3 divides by 1, 2, 4 or 8.
// Notes: The divider restarts when the counter is stopped so the first tick has full length.
`timescale 1ns/10ps
module wct_prescaler
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    logic [2:0] div_reg;
    logic [2:0] div_next;
    logic [2:0] mask;

    always_comb
    begin
        mask = 3'h0;
        case (sel_i)
            2'b00: mask = 3'h0;
            2'b01: mask = 3'h1;
            2'b10: mask = 3'h3;
            default: mask = 3'h7;
        endcase
        div_next = run_i ? 3'(div_reg + 3'h1) : 3'h0;
        tick_o = run_i && ((div_reg & mask) == mask);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            div_reg <= 3'h0;
        end
        else
        begin
            div_reg <= div_next;
        end
    end
endmodule

/* logic/wct_top.sv */
// Purpose: Sixteen-bit down counter with reload, capture, flags and output wave.
// Assumes: Registers over AXI4-Lite; pins sampled by two flip-flops.
// Notes: The narrow counter lives elsewhere; only its enable bit is kept here.
// How it works
// - Counter runs only while run enable is 1; reading shows enabled state.
// - Transmit mode: one-shot 0 reloads at terminal count, 1 stops.
// - Demodulation: one-shot 0 captures on every edge, 1 only the first.
// - Terminal count sets timeout flag; writing 1 clears it, 0 keeps it.
// - Prescale select chooses the counting clock rate.
// - Capture interrupt allow bit requests interrupt on each capture.
// - Expiry interrupt allow bit requests interrupt on each timeout.
// - Pin 35 shows port value or counter wave, chosen by select bit.
// - Shared register: wide enable bit 7, narrow bit 6, sync bit 5.
// - A wrap from 0 to FFFFh is never a timeout.
// - Disabled in normal or alternating mode, output is inverse of initial level.
// - Output control 10 or 11 forces a fixed output level always.
// - On enable load high byte times 256 plus low byte; set initial level.
// - Reaching 0 toggles output, may interrupt, and sets timeout status.
// - After 0, one-shot halts in transmit mode; auto-reload and demodulation reload and keep counting.
// - Reload bytes accept writes anytime; used only at the next load.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "wct_map.svh"
module wct_top
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic demod_pin_i,
    output logic pin35_o,
    output logic wave_o,
    output logic narrow_enable_o,
    output logic sync_mode_o,
    output logic irq_o
);
    logic [7:0] mode_reg, mode_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] sync_reg, sync_next;
    logic [7:0] rld_lo_reg, rld_lo_next;
    logic [7:0] rld_hi_reg, rld_hi_next;
    logic [7:0] cap_lo_reg, cap_lo_next;
    logic [7:0] cap_hi_reg, cap_hi_next;
    logic [1:0] stat_reg, stat_next;
    logic [1:0] mask_reg, mask_next;
    logic port_reg, port_next;
    logic [15:0] cnt_reg, cnt_next;
    logic wave_reg, wave_next;
    logic pin35_reg, pin35_next;
    wct_pkg::wct_state_t st_reg, st_next;
    logic [1:0] pin_sync_reg;
    logic pin_prev_reg;
    logic aw_hold_reg, aw_hold_next;
    logic w_hold_reg, w_hold_next;
    logic [31:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic tick;
    logic run;
    logic wr_go;
    logic rd_go;
    logic [3:0] wr_idx;
    logic edge_seen;
    logic timeout_ev;
    logic capture_ev;
    logic en_rise;
    logic pin_now;

    // Decodes a byte address into a register index; high bits must be zero.
    function automatic logic [4:0] wct_decode(input logic [31:0] addr);
        wct_decode = (addr[31:6] == 26'h0) ? {1'b1, addr[5:2]} : 5'h00;
    endfunction

    function automatic logic [7:0] wct_merge(input logic [7:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
        wct_merge = s[0] ? d[7:0] : old;
    endfunction

    // The shared and local enable are one bit seen from two registers.
    assign run = ctrl_reg[`WCT_CTRL_RUN];
    assign pin_now = pin_sync_reg[1];
    assign wr_go = (aw_hold_reg || s_axi_awvalid) && (w_hold_reg || s_axi_wvalid) && !bvalid_reg;
    assign rd_go = s_axi_arvalid && !rvalid_reg;
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    wct_prescaler u_presc
    (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .run_i(run),
        .sel_i(ctrl_reg[`WCT_CTRL_PRESC_HI:`WCT_CTRL_PRESC_LO]),
        .tick_o(tick)
    );

    always_comb
    begin
        logic [4:0] dec;
        logic [31:0] wd;
        logic [3:0] ws;
        dec = 5'h00;
        wd = 32'h0;
        ws = 4'h0;
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !s_axi_rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        wr_idx = 4'h0;
        if (s_axi_awvalid && s_axi_awready && !wr_go)
        begin
            aw_hold_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready && !wr_go)
        begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (wr_go)
        begin
            dec = wct_decode(aw_hold_reg ? awaddr_reg : s_axi_awaddr);
            wd = w_hold_reg ? wdata_reg : s_axi_wdata;
            ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (dec[4] && dec[3:0] >= `WCT_IDX_MODE && dec[3:0] <= `WCT_IDX_PORT_OUT)
                ? `WCT_RESP_OKAY : `WCT_RESP_SLVERR;
            wr_idx = (bresp_next == `WCT_RESP_OKAY && ws[0]) ? dec[3:0] : 4'h0;
            wdata_next = wd;
        end
        if (rd_go)
        begin
            dec = wct_decode(s_axi_araddr);
            rvalid_next = 1'b1;
            rresp_next = `WCT_RESP_OKAY;
            rdata_next = 32'h0;
            case (dec)
                {1'b1, `WCT_IDX_MODE}: rdata_next[7:0] = mode_reg;
                {1'b1, `WCT_IDX_CTRL}: rdata_next[7:0] = ctrl_reg;
                {1'b1, `WCT_IDX_SYNC}: rdata_next[7:0] = sync_reg;
                {1'b1, `WCT_IDX_RELOAD_LO}: rdata_next[7:0] = rld_lo_reg;
                {1'b1, `WCT_IDX_RELOAD_HI}: rdata_next[7:0] = rld_hi_reg;
                {1'b1, `WCT_IDX_CAPT_LO}: rdata_next[7:0] = cap_lo_reg;
                {1'b1, `WCT_IDX_CAPT_HI}: rdata_next[7:0] = cap_hi_reg;
                {1'b1, `WCT_IDX_IRQ_STAT}: rdata_next[1:0] = stat_reg;
                {1'b1, `WCT_IDX_IRQ_MASK}: rdata_next[1:0] = mask_reg;
                {1'b1, `WCT_IDX_PORT_OUT}: rdata_next[0] = port_reg;
                default: rresp_next = `WCT_RESP_SLVERR;
            endcase
        end
    end

    always_comb
    begin
        logic [7:0] wb;
        logic nxt_run;
        wb = wdata_next[7:0];
        mode_next = mode_reg;
        ctrl_next = ctrl_reg;
        sync_next = sync_reg;
        rld_lo_next = rld_lo_reg;
        rld_hi_next = rld_hi_reg;
        port_next = port_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        cap_lo_next = cap_lo_reg;
        cap_hi_next = cap_hi_reg;
        cnt_next = cnt_reg;
        wave_next = wave_reg;
        st_next = st_reg;
        timeout_ev = 1'b0;
        capture_ev = 1'b0;
        edge_seen = 1'b0;
        case (mode_reg[`WCT_MODE_EDGE_HI:`WCT_MODE_EDGE_LO])
            2'b00: edge_seen = pin_prev_reg && !pin_now;
            2'b01: edge_seen = !pin_prev_reg && pin_now;
            2'b10: edge_seen = pin_prev_reg != pin_now;
            default: edge_seen = 1'b0;
        endcase
        case (wr_idx)
            `WCT_IDX_MODE: mode_next = wb;
            `WCT_IDX_CTRL:
            begin
                ctrl_next = {wb[7:6], ctrl_reg[`WCT_CTRL_TIMEOUT], wb[4:0]};
                if (wb[`WCT_CTRL_TIMEOUT])
                begin
                    ctrl_next[`WCT_CTRL_TIMEOUT] = 1'b0;
                end
            end
            `WCT_IDX_SYNC:
            begin
                sync_next = {wb[7:5], 5'h00};
                ctrl_next[`WCT_CTRL_RUN] = wb[`WCT_SYNC_WIDE_EN];
            end
            `WCT_IDX_RELOAD_LO: rld_lo_next = wb;
            `WCT_IDX_RELOAD_HI: rld_hi_next = wb;
            `WCT_IDX_IRQ_STAT: stat_next = stat_reg & ~wb[1:0];
            `WCT_IDX_IRQ_MASK: mask_next = wb[1:0];
            `WCT_IDX_PORT_OUT: port_next = wb[0];
            default: mode_next = mode_reg;
        endcase
        nxt_run = ctrl_next[`WCT_CTRL_RUN];
        sync_next[`WCT_SYNC_WIDE_EN] = nxt_run;
        case (st_reg)
            wct_pkg::WCT_IDLE:
            begin
                if (nxt_run)
                begin
                    cnt_next = {rld_hi_reg, rld_lo_reg};
                    wave_next = mode_reg[`WCT_MODE_INIT_LVL];
                    st_next = mode_reg[`WCT_MODE_DEMOD] ? wct_pkg::WCT_WAIT_EDGE
                                                        : wct_pkg::WCT_RUN;
                end
            end
            wct_pkg::WCT_RUN:
            begin
                if (mode_reg[`WCT_MODE_DEMOD] && edge_seen)
                begin
                    capture_ev = 1'b1;
                    cap_lo_next = ~cnt_reg[7:0];
                    cap_hi_next = ~cnt_reg[15:8];
                    cnt_next = {rld_hi_reg, rld_lo_reg};
                    if (ctrl_reg[`WCT_CTRL_ONESHOT])
                    begin
                        st_next = wct_pkg::WCT_HALT;
                    end
                end
                else if (tick && cnt_reg != 16'h0)
                begin
                    cnt_next = cnt_reg - 16'h1;
                    if (cnt_reg == 16'h1)
                    begin
                        timeout_ev = 1'b1;
                        wave_next = !wave_reg;
                    end
                end
                else if (tick)
                begin
                    // A zero count reloads, or halts in one-shot transmit mode, instead of wrapping to FFFFh.
                    if (ctrl_reg[`WCT_CTRL_ONESHOT] && !mode_reg[`WCT_MODE_DEMOD])
                    begin
                        st_next = wct_pkg::WCT_HALT;
                    end
                    else
                    begin
                        cnt_next = {rld_hi_reg, rld_lo_reg};
                    end
                end
            end
            wct_pkg::WCT_WAIT_EDGE:
            begin
                if (edge_seen)
                begin
                    st_next = wct_pkg::WCT_RUN;
                end
            end
            default: st_next = st_reg;
        endcase
        if (!nxt_run)
        begin
            st_next = wct_pkg::WCT_IDLE;
        end
        if (timeout_ev)
        begin
            ctrl_next[`WCT_CTRL_TIMEOUT] = 1'b1;
            stat_next[`WCT_IRQ_EXPIRY] = 1'b1;
        end
        if (capture_ev)
        begin
            stat_next[`WCT_IRQ_CAPTURE] = 1'b1;
        end
    end

    always_comb
    begin
        logic w;
        w = wave_reg;
        if (mode_reg[`WCT_MODE_FORCE_HI])
        begin
            w = mode_reg[`WCT_MODE_FORCE_LO];
        end
        else if (!run)
        begin
            w = !mode_reg[`WCT_MODE_INIT_LVL];
        end
        pin35_next = ctrl_reg[`WCT_CTRL_PIN35] ? w : port_reg;
        wave_o = w;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            mode_reg <= `WCT_RESET_BYTE;
            ctrl_reg <= `WCT_RESET_BYTE;
            sync_reg <= `WCT_RESET_BYTE;
            rld_lo_reg <= `WCT_RESET_BYTE;
            rld_hi_reg <= `WCT_RESET_BYTE;
            cap_lo_reg <= `WCT_RESET_BYTE;
            cap_hi_reg <= `WCT_RESET_BYTE;
            stat_reg <= 2'h0;
            mask_reg <= 2'h0;
            port_reg <= 1'b0;
            cnt_reg <= 16'h0;
            wave_reg <= 1'b0;
            pin35_reg <= 1'b0;
            st_reg <= wct_pkg::WCT_IDLE;
            pin_sync_reg <= 2'h0;
            pin_prev_reg <= 1'b0;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 32'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= 2'h0;
        end
        else
        begin
            mode_reg <= mode_next;
            ctrl_reg <= ctrl_next;
            sync_reg <= sync_next;
            rld_lo_reg <= rld_lo_next;
            rld_hi_reg <= rld_hi_next;
            cap_lo_reg <= cap_lo_next;
            cap_hi_reg <= cap_hi_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            port_reg <= port_next;
            cnt_reg <= cnt_next;
            wave_reg <= wave_next;
            pin35_reg <= pin35_next;
            st_reg <= st_next;
            pin_sync_reg <= {pin_sync_reg[0], demod_pin_i};
            pin_prev_reg <= pin_sync_reg[1];
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign pin35_o = pin35_reg;
    assign narrow_enable_o = sync_reg[`WCT_SYNC_NARROW_EN];
    assign sync_mode_o = sync_reg[`WCT_SYNC_MODE];
    // Capture and expiry requests pass only where both mask and allow bit agree.
    assign irq_o = (stat_reg[`WCT_IRQ_EXPIRY] && mask_reg[`WCT_IRQ_EXPIRY]
                    && ctrl_reg[`WCT_CTRL_EXPIRY_IE])
                || (stat_reg[`WCT_IRQ_CAPTURE] && mask_reg[`WCT_IRQ_CAPTURE]
                    && ctrl_reg[`WCT_CTRL_CAPT_IE]);

    sequence s_last_tick;
        st_reg == wct_pkg::WCT_RUN && tick && cnt_reg == 16'h1 && !mode_reg[`WCT_MODE_DEMOD];
    endsequence

    a_timeout_sets_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_last_tick |=> ctrl_reg[`WCT_CTRL_TIMEOUT] && stat_reg[`WCT_IRQ_EXPIRY])
        else $error("Timeout flag not set at terminal count.");
    a_stopped_no_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !run && !ctrl_next[`WCT_CTRL_RUN] |=> $stable(cnt_reg))
        else $error("Counter moved while disabled.");
    a_enable_loads: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        st_reg == wct_pkg::WCT_IDLE && ctrl_next[`WCT_CTRL_RUN]
        |=> cnt_reg == {$past(rld_hi_reg), $past(rld_lo_reg)})
        else $error("Enable did not load the reload value.");
    a_oneshot_halts: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        st_reg == wct_pkg::WCT_RUN && tick && cnt_reg == 16'h0 && ctrl_reg[`WCT_CTRL_ONESHOT]
        && !mode_reg[`WCT_MODE_DEMOD] && ctrl_next[`WCT_CTRL_RUN] |=> st_reg == wct_pkg::WCT_HALT)
        else $error("One-shot counter did not halt.");
    a_no_wrap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        cnt_reg == 16'h0 |=> cnt_reg != 16'hffff || $past(rld_lo_reg) == 8'hff)
        else $error("Counter wrapped below zero.");
    a_force_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mode_reg[`WCT_MODE_FORCE_HI] |-> wave_o == mode_reg[`WCT_MODE_FORCE_LO])
        else $error("Forced output level not held.");
    a_idle_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !run && !mode_reg[`WCT_MODE_FORCE_HI] |-> wave_o != mode_reg[`WCT_MODE_INIT_LVL])
        else $error("Disabled output level wrong.");
    a_pin35_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ctrl_reg[`WCT_CTRL_PIN35] ##1 ctrl_reg[`WCT_CTRL_PIN35] |-> pin35_o == $past(wave_o))
        else $error("Pin 35 does not follow the wave.");
endmodule

/* verification/test_wide_counter_timer_control.sv */
// Purpose: Self-checking bench for the wide counter over AXI4-Lite.
// Assumes: Byte address is four times the register index; data in bits 7:0.
// Notes: Most expected values are constants; exp_reg keeps written values for the reload check.
`timescale 1ns/10ps
`include "wct_map.svh"
module test_wide_counter_timer_control;
logic clk_sys_i, rst_i, awvalid, wvalid, bready, arvalid, rready, demod_pin_i;
logic awready, wready, bvalid, arready, rvalid, pin35_o, wave_o, narrow_o, sync_o, irq_o;
logic [31:0] awaddr, wdata, araddr, rdata, rd;
logic [1:0] bresp, rresp, resp;
int n_mismatch, comparisons, n, nexp, sel;
int exp_reg [16];
logic [7:0] mv [4] = '{8'h0c, 8'h08, 8'h01, 8'h00};
logic wv [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
wct_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .demod_pin_i(demod_pin_i), .pin35_o(pin35_o), .wave_o(wave_o),
    .narrow_enable_o(narrow_o), .sync_mode_o(sync_o), .irq_o(irq_o));
initial
begin
    clk_sys_i = 0;
    forever #2 clk_sys_i = ~clk_sys_i;
end
task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
        n_mismatch++;
        $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic give_up();
    n_mismatch++;
    $display("unexpected wait timeout");
    final_report();
endtask
task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    exp_reg[idx] = d;
    @(posedge clk_sys_i);
    awaddr <= {26'h0, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
        @(posedge clk_sys_i);
        k++;
        if (awvalid && awready) awvalid <= 0;
        if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1 && k < 50);
    if (k >= 50) give_up();
    resp = bresp;
    bready <= 0;
endtask
task automatic rdr(input logic [3:0] idx);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    araddr <= {26'h0, idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do
    begin
        @(posedge clk_sys_i);
        k++;
        if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1 && k < 50);
    if (k >= 50) give_up();
    rd = rdata;
    resp = rresp;
    rready <= 0;
endtask
task automatic poll(input logic [3:0] idx, input int b);
    int k;
    k = 0;
    do
    begin
        rdr(idx);
        k++;
    end while (rd[b] !== 1'b1 && k < 200);
    if (k >= 200) give_up();
endtask
initial
begin
    {awvalid, wvalid, bready, arvalid, rready, demod_pin_i} = '0;
    awaddr = '0;
    wdata = '0;
    araddr = '0;
    n_mismatch = 0;
    comparisons = 0;
    rst_i = 1;
    void'($urandom(51));
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 0;
    rdr(`WCT_IDX_CTRL); check("ctrl reset", rd, 32'h0);
    rdr(`WCT_IDX_SYNC); check("shared reset", rd, 32'h0);
    check("idle wave", {31'h0, wave_o}, 32'h1);
    rdr(4'hf); check("unmapped resp", {30'h0, resp}, {30'h0, `WCT_RESP_SLVERR});
    wr(4'hf, 8'h00);
    check("unmapped write", {30'h0, resp}, {30'h0, `WCT_RESP_SLVERR});
    $display("test reset done");
    wr(`WCT_IDX_SYNC, 8'he0);
    check("write resp", {30'h0, resp}, {30'h0, `WCT_RESP_OKAY});
    rdr(`WCT_IDX_SYNC); check("shared", rd, 32'he0);
    check("narrow en", {31'h0, narrow_o}, 32'h1);
    check("sync mode", {31'h0, sync_o}, 32'h1);
    wr(`WCT_IDX_SYNC, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
        wr(`WCT_IDX_MODE, mv[i]); check("forced wave", {31'h0, wave_o}, {31'h0, wv[i]});
    end
    wr(`WCT_IDX_PORT_OUT, 8'h01); repeat (2) @(posedge clk_sys_i);
    check("pin port", {31'h0, pin35_o}, 32'h1);
    wr(`WCT_IDX_PORT_OUT, 8'h00); wr(`WCT_IDX_CTRL, 8'h01); repeat (2) @(posedge clk_sys_i);
    check("pin wave", {31'h0, pin35_o}, 32'h1);
    $display("test output select done");
    sel = $urandom % 4;
    n = 2 + $urandom % 6;
    nexp = n << sel;
    wr(`WCT_IDX_RELOAD_LO, n[7:0]); wr(`WCT_IDX_RELOAD_HI, 8'h00); wr(`WCT_IDX_IRQ_MASK, 8'h01);
    wr(`WCT_IDX_CTRL, 8'hc2 | (sel[7:0] << `WCT_CTRL_PRESC_LO));
    check("wave at start", {31'h0, wave_o}, 32'h0);
    n = 0;
    while (irq_o !== 1'b1 && n < 500)
    begin
        @(posedge clk_sys_i);
        n++;
    end
    if (n >= 500) give_up();
    check("period", (n >= nexp - 2 && n <= nexp + 4), 32'h1);
    check("toggled wave", {31'h0, wave_o}, 32'h1);
    wr(`WCT_IDX_CTRL, 8'h00); rdr(`WCT_IDX_CTRL); check("flag kept", rd[5], 32'h1);
    wr(`WCT_IDX_CTRL, 8'h20); rdr(`WCT_IDX_CTRL); check("flag clear", rd[5], 32'h0);
    wr(`WCT_IDX_IRQ_STAT, 8'h01); check("irq cleared", {31'h0, irq_o}, 32'h0);
    $display("test one shot done");
    wr(`WCT_IDX_IRQ_MASK, 8'h00); wr(`WCT_IDX_RELOAD_LO, 8'h04); wr(`WCT_IDX_CTRL, 8'h82);
    poll(`WCT_IDX_IRQ_STAT, `WCT_IRQ_EXPIRY);
    check("masked irq", {31'h0, irq_o}, 32'h0);
    wr(`WCT_IDX_RELOAD_LO, 8'h09); rdr(`WCT_IDX_RELOAD_LO);
    check("reload", rd, exp_reg[`WCT_IDX_RELOAD_LO]);
    wr(`WCT_IDX_IRQ_STAT, 8'h01); poll(`WCT_IDX_IRQ_STAT, `WCT_IRQ_EXPIRY);
    rdr(`WCT_IDX_CTRL); check("still running", rd[7], 32'h1);
    wr(`WCT_IDX_IRQ_MASK, 8'h01); check("unmasked irq", {31'h0, irq_o}, 32'h1);
    wr(`WCT_IDX_CTRL, 8'h00);
    wr(`WCT_IDX_CTRL, 8'h20);
    wr(`WCT_IDX_IRQ_STAT, 8'h03);
    $display("test auto reload done");
    wr(`WCT_IDX_MODE, 8'h90);
    wr(`WCT_IDX_RELOAD_LO, 8'hff); wr(`WCT_IDX_RELOAD_HI, 8'hff);
    wr(`WCT_IDX_IRQ_MASK, 8'h02); wr(`WCT_IDX_CTRL, 8'h84);
    for (int i = 0; i < 2; i++)
    begin
        repeat (20) @(posedge clk_sys_i);
        demod_pin_i <= 1;
        repeat (20) @(posedge clk_sys_i);
        demod_pin_i <= 0;
    end
    repeat (4) @(posedge clk_sys_i);
    check("capture irq", {31'h0, irq_o}, 32'h1);
    rdr(`WCT_IDX_IRQ_STAT); check("capture flag", rd[1], 32'h1);
    rdr(`WCT_IDX_CAPT_HI); check("capture high", rd, 32'h0);
    rdr(`WCT_IDX_CAPT_LO);
    check("capture low", (rd >= 32'h24 && rd <= 32'h28), 32'h1);
    $display("test demodulation done");
    wr(`WCT_IDX_CTRL, 8'h00);
    wr(`WCT_IDX_IRQ_STAT, 8'h02);
    wr(`WCT_IDX_MODE, 8'ha0);
    wr(`WCT_IDX_CTRL, 8'hc4);
    for (int i = 0; i < 3; i++)
    begin
        repeat (12) @(posedge clk_sys_i);
        demod_pin_i <= ~demod_pin_i;
        if (i == 1)
        begin
            repeat (6) @(posedge clk_sys_i);
            rdr(`WCT_IDX_IRQ_STAT);
            check("first edge capture", rd[1], 32'h1);
            rdr(`WCT_IDX_CAPT_LO);
            check("both edge count", (rd >= 32'h09 && rd <= 32'h0c), 32'h1);
            wr(`WCT_IDX_IRQ_STAT, 8'h02);
        end
    end
    repeat (6) @(posedge clk_sys_i);
    rdr(`WCT_IDX_IRQ_STAT);
    check("later edge ignored", rd[1], 32'h0);
    $display("test single capture done");
    final_report();
end
endmodule
